// >>> common/addr_dec_defines.vh
`ifndef ADDR_DEC_DEFINES_VH
`define ADDR_DEC_DEFINES_VH

// Register addresses in the reserved top page
`define BANK_SEL_ADDR     16'hff00
`define DEC_CFG_ADDR      16'hff01
// Select windows
`define SEL_A_LO          16'hff04
`define SEL_A_HI          16'hff07
`define SEL_B_LO          16'hff08
`define SEL_B_HI          16'hff0b
// Layout codes
`define LAYOUT_COMPAT     2'h0
`define LAYOUT_BANKED     2'h1
`define LAYOUT_LINEAR     2'h2
// Select function codes
`define FN_WR_STROBE      2'h0
`define FN_RD_STROBE      2'h1
`define FN_DECODE         2'h2
`define FN_STATIC         2'h3
// Config fields
`define CFG_LAYOUT_LSB    0
`define CFG_A_FN_LSB      2
`define CFG_A_POL_BIT     4
`define CFG_B_FN_LSB      5
`define CFG_B_POL_BIT     7
`define CFG_RESET         8'h00
`define BANK_RESET        4'h0
// Address windows
`define LOW_RAM_TOP       16'h7fff
`define BANK_WIN_LO       16'h8000
`define BANK_WIN_HI       16'hbfff
`define NIC_COMPAT_LO     16'h8000
`define NIC_COMPAT_HI     16'h9000
`define NIC_BANKED_LO     16'hc000
`define NIC_BANKED_HI     16'hfeff
`define NIC_LINEAR_LO     16'hff80
`define LINEAR_RAM_TOP    16'hfeff
// Bank geometry: 16kB banks, 18-bit RAM address
`define BANK_OFS_BITS     14
`define RAM_ADDR_BITS     18

`endif

// >>> design/select_output.v
`timescale 1ns/1ps
`include "addr_dec_defines.vh"

module select_output (
	input  wire [15:0] addr,
	input  wire        wr_n,
	input  wire        rd_n,
	input  wire [15:0] win_lo,
	input  wire [15:0] win_hi,
	input  wire [1:0]  func,
	input  wire        pol,
	input  wire        static_level,
	output reg         sel
);

	reg hit;
	reg act;

	// Purely combinational so the pulse tracks the strobe edges
	always @* begin
		hit = (addr >= win_lo) && (addr <= win_hi);
		case (func)
		`FN_WR_STROBE: act = hit && !wr_n;
		`FN_RD_STROBE: act = hit && !rd_n;
		`FN_DECODE:    act = hit && (!wr_n || !rd_n);
		default:       act = 1'b0;
		endcase
		if (func == `FN_STATIC)
			sel = static_level;
		else
			sel = pol ? act : !act;
	end

endmodule // select_output

// >>> design/address_decoder_bank_select.v
`timescale 1ns/1ps
`include "addr_dec_defines.vh"

module address_decoder_bank_select (
	input  wire        mclk,
	input  wire        rst_b,
	input  wire [15:0] addr,
	input  wire        wr_n,
	input  wire        rd_n,
	input  wire [7:0]  data_in,
	input  wire        ram_256k,
	output reg  [7:0]  data_out,
	output wire        data_oe,
	output wire        ram_cs_n,
	output wire [17:0] ram_addr,
	output wire        nic_cs_n,
	output wire        select_out_a,
	output wire        select_out_b
);

	reg  [7:0] decoder_config_q;
	reg  [3:0] bank_select_register_q;
	reg        wr_s1_q;
	reg        wr_s2_q;
	reg        wr_s3_q;
	reg        r256_s1_q;
	reg        r256_s2_q;
	wire       wr_rise;
	wire [1:0] layout;
	wire       sel_b_raw;
	reg        ram_hit;
	reg        nic_hit;
	reg  [3:0] bank;

	assign layout = decoder_config_q[`CFG_LAYOUT_LSB +: 2];

	// Host strobes are asynchronous: synchronise before commit
	always @(posedge mclk) begin
		wr_s1_q   <= wr_n;
		wr_s2_q   <= wr_s1_q;
		wr_s3_q   <= wr_s2_q;
		r256_s1_q <= ram_256k;
		r256_s2_q <= r256_s1_q;
	end
	// Commit on strobe release; address/data still held by host
	assign wr_rise = wr_s2_q && !wr_s3_q;

	always @(posedge mclk) begin
		if (!rst_b) begin
			decoder_config_q       <= `CFG_RESET;
			bank_select_register_q <= `BANK_RESET;
		end else if (wr_rise) begin
			if (addr == `DEC_CFG_ADDR)
				decoder_config_q <= data_in;
			if (addr == `BANK_SEL_ADDR)
				bank_select_register_q <= data_in[3:0];
		end
	end

	// Readback: only bank register; config reads leave data_oe low
	always @(posedge mclk) begin
		if (!rst_b)
			data_out <= 8'h00;
		else
			data_out <= {4'h0, bank_select_register_q};
	end
	// Config read left undriven by us: bus floats, value undefined
	assign data_oe = !rd_n && (addr == `BANK_SEL_ADDR);

	always @* begin
		ram_hit = 1'b0;
		nic_hit = 1'b0;
		bank    = 4'h0;
		case (layout)
		`LAYOUT_COMPAT: begin
			ram_hit = addr <= `LOW_RAM_TOP;
			nic_hit = (addr >= `NIC_COMPAT_LO) &&
				(addr <= `NIC_COMPAT_HI);
			bank    = {3'h0, addr[14]};
		end
		`LAYOUT_BANKED: begin
			ram_hit = addr <= `BANK_WIN_HI;
			nic_hit = (addr >= `NIC_BANKED_LO) &&
				(addr <= `NIC_BANKED_HI) &&
				(addr < `SEL_A_LO);
			if (addr >= `BANK_WIN_LO)
				bank = bank_select_register_q;
			else
				// Last bank pair holds the fixed 32kB
				bank = (r256_s2_q ? 4'he : 4'h6) |
					{3'h0, addr[14]};
		end
		`LAYOUT_LINEAR: begin
			ram_hit = addr <= `LINEAR_RAM_TOP;
			nic_hit = addr >= `NIC_LINEAR_LO;
			bank    = {2'h0, addr[15:14]};
		end
		default: begin
			ram_hit = 1'b0;
			nic_hit = 1'b0;
			bank    = 4'h0;
		end
		endcase
	end

	assign ram_cs_n = !(ram_hit && (!wr_n || !rd_n));
	assign nic_cs_n = !nic_hit;
	// Banks beyond 128kB use address bit 17
	assign ram_addr = {bank, addr[`BANK_OFS_BITS-1:0]};

	select_output u_sel_a (
		.addr         (addr),
		.wr_n         (wr_n),
		.rd_n         (rd_n),
		.win_lo       (`SEL_A_LO),
		.win_hi       (`SEL_A_HI),
		.func         (decoder_config_q[`CFG_A_FN_LSB +: 2]),
		.pol          (decoder_config_q[`CFG_A_POL_BIT]),
		.static_level (decoder_config_q[`CFG_A_POL_BIT]),
		.sel          (select_out_a)
	);

	select_output u_sel_b (
		.addr         (addr),
		.wr_n         (wr_n),
		.rd_n         (rd_n),
		.win_lo       (`SEL_B_LO),
		.win_hi       (`SEL_B_HI),
		.func         (decoder_config_q[`CFG_B_FN_LSB +: 2]),
		.pol          (decoder_config_q[`CFG_B_POL_BIT]),
		.static_level (bank_select_register_q[3]),
		.sel          (sel_b_raw)
	);

	// On 256kB builds B carries the top RAM address bit
	assign select_out_b = r256_s2_q ? bank[3] : sel_b_raw;

endmodule // address_decoder_bank_select

// >>> tb/address_decoder_bank_select_monitor.sv
`timescale 1ns/1ps
module adbs_chk (
	input wire        mclk,
	input wire        rst_b,
	input wire [15:0] addr,
	input wire        wr_n,
	input wire        rd_n,
	input wire [7:0]  data_out,
	input wire        data_oe,
	input wire        ram_cs_n,
	input wire [17:0] ram_addr,
	input wire        nic_cs_n,
	input wire        select_out_a,
	input wire        select_out_b,
	input wire        ram_256k
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	wire a_win = addr >= 16'hff04 && addr <= 16'hff07;
	chk_cfg_undriven: assert property (
		data_oe == (!rd_n && addr == 16'hff00)) else $error("oe wrong");
	chk_bank_pad: assert property (data_out[7:4] == 4'h0)
		else $error("bank pad set");
	chk_ram_ofs: assert property (
		!ram_cs_n |-> ram_addr[13:0] == addr[13:0]) else $error("ofs");
	chk_cs_excl: assert property (!nic_cs_n |-> ram_cs_n)
		else $error("both selects low");
	// Reset config is a low write strobe on A
	// Config is unknown until the first reset edge has passed
	chk_sel_rst: assert property (disable iff (1'b0)
		!rst_b ##1 !rst_b |-> select_out_a == !(a_win && !wr_n))
		else $error("sel");
	// Strap passes two flops before it steers select B
	chk_b_top_bit: assert property (
		ram_256k && $past(ram_256k) && $past(ram_256k, 2) |->
		select_out_b == ram_addr[17]) else $error("top bit");
	cover property (data_oe);
	cover property (!nic_cs_n);
	cover property (select_out_a && !wr_n);
endmodule // adbs_chk
bind address_decoder_bank_select adbs_chk adbs_chk_inst (.mclk, .rst_b,
	.addr, .wr_n, .rd_n, .data_out, .data_oe, .ram_cs_n, .ram_addr,
	.nic_cs_n, .select_out_a, .select_out_b, .ram_256k);

// >>> tb/host_bus.sv
`timescale 1ns/1ps
module host_bus (
	input  wire         mclk,
	output logic [15:0] addr = 16'h0000,
	output logic        wr_n = 1'b1,
	output logic        rd_n = 1'b1,
	output logic [7:0]  data_in = 8'h00
);
	task automatic drive(input logic [15:0] a, input logic [7:0] d,
		input logic w, input logic r);
		@(posedge mclk);
		#1;
		addr = a;
		data_in = d;
		wr_n = !w;
		rd_n = !r;
	endtask
	task automatic write(input logic [15:0] a, input logic [7:0] d);
		drive(a, d, 1'b1, 1'b0);
		repeat (4) @(posedge mclk);
		#1;
		wr_n = 1'b1;
		// Commit lags the rising strobe, so hold address and data
		repeat (4) @(posedge mclk);
		#1;
		data_in = ~d;
	endtask
endmodule // host_bus

// >>> tb/address_decoder_bank_select_tb.sv
`timescale 1ns/1ps
module address_decoder_bank_select_tb;
	logic        mclk, rst_b, ram_256k, p, w, r;
	wire  [15:0] addr;
	wire         wr_n, rd_n, data_oe, ram_cs_n, nic_cs_n;
	wire         select_out_a, select_out_b;
	wire  [7:0]  data_in, data_out;
	wire  [17:0] ram_addr;
	int          err_total, checked, cyc;
	integer      seed = 32'h72673fd7;
	logic [7:0]  v;
	logic [3:0]  bank;
	logic [1:0]  f;
	logic [15:0] a;
	logic [15:0] ta [6] = '{16'h1000, 16'h5000, 16'h8000, 16'ha000,
		16'hc000, 16'hff80};
	host_bus host_bus_inst (.mclk, .addr, .wr_n, .rd_n, .data_in);
	address_decoder_bank_select address_decoder_bank_select_inst (.mclk,
		.rst_b, .addr, .wr_n, .rd_n, .data_in, .ram_256k, .data_out,
		.data_oe, .ram_cs_n, .ram_addr, .nic_cs_n, .select_out_a,
		.select_out_b);
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic sexp(input logic [1:0] f, input logic p,
		input logic hit, input logic w, input logic r);
		if (f == 2'h3)
			return p;
		return ((f == 2'h0 ? w : f == 2'h1 ? r : w | r) && hit) ? p : !p;
	endfunction
	task automatic test_done();
		$display("errors=%0d checks=%0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		rst_b = 1'b0;
		ram_256k = 1'b0;
		repeat (16) @(posedge mclk);
		#1 rst_b = 1'b1;
		v = $random(seed);
		bank = v[3:0];
		host_bus_inst.write(16'hff00, v);
		host_bus_inst.drive(16'hff00, 8'h00, 1'b0, 1'b1);
		#1 chk(data_oe, 1'b1);
		@(posedge mclk);
		#1 chk(data_out, {4'h0, bank});
		host_bus_inst.drive(16'hff01, 8'h00, 1'b0, 1'b1);
		#1 chk(data_oe, 1'b0);
		for (int i = 0; i < 8; i++) begin
			f = i[1:0];
			p = i[2];
			host_bus_inst.write(16'hff01, {p, f, p, f, 2'h0});
			for (int j = 0; j < 6; j++) begin
				v = $random(seed);
				w = v[0];
				r = v[1] & !v[0];
				a = 16'hff02 + v[5:2];
				host_bus_inst.drive(a, 8'h00, w, r);
				#1 chk(select_out_a, sexp(f, p, a >= 16'hff04 && a <= 16'hff07,
					w, r));
				chk(select_out_b, f == 2'h3 ? bank[3] : sexp(f, p,
					a >= 16'hff08 && a <= 16'hff0b, w, r));
			end
		end
		for (int l = 0; l < 3; l++) begin
			host_bus_inst.write(16'hff01, l[7:0]);
			foreach (ta[t]) begin
				a = ta[t];
				host_bus_inst.drive(a, 8'h00, 1'b0, 1'b1);
				#1 chk(ram_cs_n, !(l == 0 ? a <= 16'h7fff : l == 1 ?
					a <= 16'hbfff : a <= 16'hfeff));
				chk(nic_cs_n, !(l == 0 ? a >= 16'h8000 && a <= 16'h9000 :
					l == 1 ? a == 16'hc000 : a >= 16'hff80));
				if (l == 1 && (a == 16'ha000 || a == 16'h5000))
					chk(ram_addr, {a[15] ? bank : 4'h7, a[13:0]});
			end
		end
		@(posedge mclk);
		#1 ram_256k = 1'b1;
		host_bus_inst.write(16'hff01, 8'h61);
		for (int k = 0; k < 2; k++) begin
			bank = {k[0], 3'h5};
			host_bus_inst.write(16'hff00, {4'h0, bank});
			host_bus_inst.drive(16'ha000, 8'h00, 1'b0, 1'b1);
			#1 chk(select_out_b, bank[3]);
			chk(ram_addr, {bank, 14'h2000});
		end
		test_done();
	end
endmodule // address_decoder_bank_select_tb
